// >>> rtl/uhil_pkg.sv
package uhil_pkg;

   localparam int UHIL_AW = 8;
   localparam int UHIL_DW = 32;

   // Register offsets (byte addresses)
   localparam logic [7:0] UHIL_OFF_ENABLE = 8'h10;
   localparam logic [7:0] UHIL_OFF_DISABLE = 8'h14;
   localparam logic [7:0] UHIL_OFF_COMM = 8'h18;
   localparam logic [7:0] UHIL_OFF_PERIODIC = 8'h1C;
   localparam logic [7:0] UHIL_OFF_CTL_HEAD = 8'h20;
   localparam logic [7:0] UHIL_OFF_CTL_CUR = 8'h24;

   // Interrupt enable field positions
   localparam int UHIL_BIT_MASTER = 31;
   localparam int UHIL_BIT_OWNER_CHANGE = 30;
   localparam int UHIL_BIT_HUB_CHANGE = 6;
   localparam int UHIL_BIT_FRAME_WRAP = 5;
   localparam int UHIL_BIT_FATAL_ERROR = 4;
   localparam int UHIL_BIT_WAKEUP = 3;
   localparam int UHIL_BIT_FRAME_START = 2;
   localparam int UHIL_BIT_WRITEBACK = 1;
   localparam int UHIL_BIT_OVERRUN = 0;

   // Enable bits that exist; the fatal error event has no enable
   localparam logic [31:0] UHIL_IRQ_IMPL_MASK =
      (32'h1 << UHIL_BIT_MASTER) | (32'h1 << UHIL_BIT_OWNER_CHANGE) |
      (32'h1 << UHIL_BIT_HUB_CHANGE) | (32'h1 << UHIL_BIT_FRAME_WRAP) |
      (32'h1 << UHIL_BIT_WAKEUP) | (32'h1 << UHIL_BIT_FRAME_START) |
      (32'h1 << UHIL_BIT_WRITEBACK) | (32'h1 << UHIL_BIT_OVERRUN);
   localparam logic [31:0] UHIL_EVENT_MASK =
      UHIL_IRQ_IMPL_MASK & ~(32'h1 << UHIL_BIT_MASTER);

   // Writable fields of the pointer registers
   localparam logic [31:0] UHIL_COMM_MASK = 32'hFFFFFF00;
   localparam logic [31:0] UHIL_DESC_MASK = 32'hFFFFFFF0;

   localparam logic [31:0] UHIL_REG_RESET = 32'h00000000;
   localparam logic [31:0] UHIL_READ_NONE = 32'h00000000;

   function automatic logic uhil_hit(input logic [7:0] addr, input logic [7:0] off);
      return addr == off;
   endfunction

   function automatic logic [31:0] uhil_field(input logic [31:0] data, input logic [31:0] mask);
      return data & mask;
   endfunction

endpackage

// >>> rtl/uhil_irq_enable.sv
`timescale 1ns/1ns
`default_nettype none
module uhil_irq_enable
   import uhil_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic set_write,
   input wire logic clear_write,
   input wire logic [31:0] wdata,
   input wire logic [31:0] events,
   output logic [31:0] enable,
   output logic irq_req
);

   always_ff @(posedge clk) begin
      if (rst) begin
         enable <= UHIL_REG_RESET;
      end else if (set_write) begin
         enable <= enable | uhil_field(wdata, UHIL_IRQ_IMPL_MASK);
      end else if (clear_write) begin
         enable <= enable & ~uhil_field(wdata, UHIL_IRQ_IMPL_MASK);
      end
   end

   // Event, its enable and the master gate must all be set
   assign irq_req = enable[UHIL_BIT_MASTER] & (|(events & enable & UHIL_EVENT_MASK));

endmodule // uhil_irq_enable
`default_nettype wire

// >>> rtl/uhil_ptr_reg.sv
`timescale 1ns/1ns
`default_nettype none
module uhil_ptr_reg
   import uhil_pkg::*;
#(
   parameter logic [31:0] KEEP = UHIL_DESC_MASK
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic sw_write,
   input wire logic [31:0] sw_data,
   input wire logic hw_load,
   input wire logic [31:0] hw_data,
   output logic [31:0] value
);

   // Controller update wins over a software write in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         value <= UHIL_REG_RESET;
      end else if (hw_load) begin
         value <= uhil_field(hw_data, KEEP);
      end else if (sw_write) begin
         value <= uhil_field(sw_data, KEEP);
      end
   end

endmodule // uhil_ptr_reg
`default_nettype wire

// >>> rtl/uhil_regs.sv
`timescale 1ns/1ns
`default_nettype none
module uhil_regs
   import uhil_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic SW_RESET,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire logic [31:0] EVENT_STATUS,
   output logic IRQ_REQ,
   output logic [31:0] IRQ_ENABLE,
   input wire logic PERIODIC_UPDATE,
   input wire logic [31:0] PERIODIC_ADDR,
   input wire logic CONTROL_HEAD_LOAD,
   input wire logic [31:0] CONTROL_HEAD_DATA,
   input wire logic CONTROL_ADVANCE,
   input wire logic [31:0] CONTROL_NEXT,
   output logic [31:0] COMM_AREA_BASE,
   output logic [31:0] PERIODIC_CURRENT,
   output logic [31:0] CONTROL_HEAD,
   output logic [31:0] CONTROL_CURRENT
);

   logic rst_any;
   logic wr_enable;
   logic wr_disable;
   logic wr_comm;
   logic wr_periodic;
   logic wr_ctl_head;
   logic wr_ctl_cur;
   logic [31:0] irq_en;
   logic [31:0] comm_base;
   logic [31:0] periodic_ptr;
   logic [31:0] control_head_ptr;
   logic [31:0] control_current_ptr;
   logic [31:0] next_rdata;

   // Hardware and software reset act alike on the five registers; RDATA is reset by RST only
   assign rst_any = RST | SW_RESET;

   assign wr_enable = WR & uhil_hit(ADDR, UHIL_OFF_ENABLE);
   assign wr_disable = WR & uhil_hit(ADDR, UHIL_OFF_DISABLE);
   assign wr_comm = WR & uhil_hit(ADDR, UHIL_OFF_COMM);
   assign wr_periodic = WR & uhil_hit(ADDR, UHIL_OFF_PERIODIC);
   assign wr_ctl_head = WR & uhil_hit(ADDR, UHIL_OFF_CTL_HEAD);
   assign wr_ctl_cur = WR & uhil_hit(ADDR, UHIL_OFF_CTL_CUR);

   // Enable register: set through its own offset, cleared through disable
   uhil_irq_enable u_irq_enable (
      .clk(CLK),
      .rst(rst_any),
      .set_write(wr_enable),
      .clear_write(wr_disable),
      .wdata(WDATA),
      .events(EVENT_STATUS),
      .enable(irq_en),
      .irq_req(IRQ_REQ)
   );

   // Communication area base: 256-byte alignment forced
   uhil_ptr_reg #(
      .KEEP(UHIL_COMM_MASK)
   ) u_comm_base (
      .clk(CLK),
      .rst(rst_any),
      .sw_write(wr_comm),
      .sw_data(WDATA),
      .hw_load(1'b0),
      .hw_data(UHIL_REG_RESET),
      .value(comm_base)
   );

   // Periodic current descriptor, advanced by the list engine
   uhil_ptr_reg #(
      .KEEP(UHIL_DESC_MASK)
   ) u_periodic (
      .clk(CLK),
      .rst(rst_any),
      .sw_write(wr_periodic),
      .sw_data(WDATA),
      .hw_load(PERIODIC_UPDATE),
      .hw_data(PERIODIC_ADDR),
      .value(periodic_ptr)
   );

   // Control head, loaded from the shared area during initialization
   uhil_ptr_reg #(
      .KEEP(UHIL_DESC_MASK)
   ) u_ctl_head (
      .clk(CLK),
      .rst(rst_any),
      .sw_write(wr_ctl_head),
      .sw_data(WDATA),
      .hw_load(CONTROL_HEAD_LOAD),
      .hw_data(CONTROL_HEAD_DATA),
      .value(control_head_ptr)
   );

   // Control current descriptor, advanced as each one is served
   uhil_ptr_reg #(
      .KEEP(UHIL_DESC_MASK)
   ) u_ctl_cur (
      .clk(CLK),
      .rst(rst_any),
      .sw_write(wr_ctl_cur),
      .sw_data(WDATA),
      .hw_load(CONTROL_ADVANCE),
      .hw_data(CONTROL_NEXT),
      .value(control_current_ptr)
   );

   assign IRQ_ENABLE = irq_en;
   assign COMM_AREA_BASE = comm_base;
   assign PERIODIC_CURRENT = periodic_ptr;
   assign CONTROL_HEAD = control_head_ptr;
   assign CONTROL_CURRENT = control_current_ptr;

   // Read decode; unmapped offsets read zero
   always_comb begin
      next_rdata = UHIL_READ_NONE;
      if (RD) begin
         unique case (ADDR)
            UHIL_OFF_ENABLE: next_rdata = irq_en;
            UHIL_OFF_DISABLE: next_rdata = irq_en;
            UHIL_OFF_COMM: next_rdata = comm_base;
            UHIL_OFF_PERIODIC: next_rdata = periodic_ptr;
            UHIL_OFF_CTL_HEAD: next_rdata = control_head_ptr;
            UHIL_OFF_CTL_CUR: next_rdata = control_current_ptr;
            default: next_rdata = UHIL_READ_NONE;
         endcase
      end
   end

   // Read data stands only in the cycle after the read strobe
   always_ff @(posedge CLK) begin
      if (RST) begin
         RDATA <= UHIL_READ_NONE;
      end else begin
         RDATA <= next_rdata;
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (rst_any);

   a_disable_clears: assert property (
      wr_disable |=> ((irq_en & $past(WDATA)) == 32'h00000000))
      else $error("disable write left an enable bit set");

   a_disable_keeps: assert property (
      wr_disable |=> ((irq_en & ~$past(WDATA)) == ($past(irq_en) & ~$past(WDATA))))
      else $error("disable write changed a bit written as zero");

   a_disable_readback: assert property (
      RD && uhil_hit(ADDR, UHIL_OFF_DISABLE) |=> RDATA == $past(irq_en))
      else $error("disable read did not return the enable register");

   a_master_off: assert property (
      wr_disable && WDATA[UHIL_BIT_MASTER] |=> !irq_en[UHIL_BIT_MASTER] && !IRQ_REQ)
      else $error("master gate still on after disable");

   a_master_zero_ignored: assert property (
      wr_disable && !WDATA[UHIL_BIT_MASTER] |=> $stable(irq_en[UHIL_BIT_MASTER]))
      else $error("zero write moved the master gate");

   a_reset_master: assert property (
      @(posedge CLK) disable iff (1'b0)
      RST || SW_RESET |=> !irq_en[UHIL_BIT_MASTER] && !IRQ_REQ)
      else $error("master gate not disabled after reset");

   a_reset_zero: assert property (
      @(posedge CLK) disable iff (1'b0)
      RST || SW_RESET |=> (irq_en | comm_base | periodic_ptr | control_head_ptr | control_current_ptr) == 32'h0)
      else $error("register not zero after reset");

   a_event_bits_clear: assert property (
      wr_disable && (WDATA[UHIL_BIT_OWNER_CHANGE] || WDATA[UHIL_BIT_HUB_CHANGE])
      |=> !(irq_en[UHIL_BIT_OWNER_CHANGE] && $past(WDATA[UHIL_BIT_OWNER_CHANGE]))
      && !(irq_en[UHIL_BIT_HUB_CHANGE] && $past(WDATA[UHIL_BIT_HUB_CHANGE])))
      else $error("owner or hub enable not cleared");

   a_frame_wrap_clear: assert property (
      wr_disable && WDATA[UHIL_BIT_FRAME_WRAP] |=> !irq_en[UHIL_BIT_FRAME_WRAP])
      else $error("frame wrap enable not cleared");

   a_low_bits_clear: assert property (
      wr_disable && WDATA[UHIL_BIT_WAKEUP] |=> !irq_en[UHIL_BIT_WAKEUP])
      else $error("wakeup enable not cleared");

   a_frame_start_clear: assert property (
      wr_disable && WDATA[UHIL_BIT_FRAME_START] |=> !irq_en[UHIL_BIT_FRAME_START])
      else $error("frame start enable not cleared");

   a_writeback_clear: assert property (
      wr_disable && WDATA[UHIL_BIT_WRITEBACK] |=> !irq_en[UHIL_BIT_WRITEBACK])
      else $error("writeback enable not cleared");

   a_overrun_clear: assert property (
      wr_disable && WDATA[UHIL_BIT_OVERRUN] |=> !irq_en[UHIL_BIT_OVERRUN])
      else $error("overrun enable not cleared");

   a_fatal_ignored: assert property (
      wr_enable && WDATA[UHIL_BIT_FATAL_ERROR] |=> !irq_en[UHIL_BIT_FATAL_ERROR])
      else $error("fatal error enable bit took a write");

   a_fatal_disable: assert property (
      wr_disable && ((WDATA & ~(32'h1 << UHIL_BIT_FATAL_ERROR)) == 32'h00000000) |=> $stable(irq_en))
      else $error("write to the unused disable bit changed state");

   a_fatal_bit_zero: assert property (
      RD && uhil_hit(ADDR, UHIL_OFF_DISABLE) |=> !RDATA[UHIL_BIT_FATAL_ERROR])
      else $error("unused enable bit read as one");

   a_enable_reserved: assert property (
      (irq_en & ~UHIL_IRQ_IMPL_MASK) == 32'h00000000)
      else $error("reserved enable bit set");

   a_enable_keeps: assert property (
      !wr_enable && !wr_disable |=> $stable(irq_en))
      else $error("enable register changed without a write");

   a_enable_readback: assert property (
      RD && uhil_hit(ADDR, UHIL_OFF_ENABLE) |=> RDATA == $past(irq_en))
      else $error("enable read did not return the enable register");

   a_comm_align: assert property (
      RD && uhil_hit(ADDR, UHIL_OFF_COMM) |=> RDATA[7:0] == 8'h00)
      else $error("communication base low bits not zero");

   a_comm_hold: assert property (
      wr_comm |=> comm_base == {$past(WDATA[31:8]), 8'h00})
      else $error("communication base did not take the write");

   a_comm_keep: assert property (
      !wr_comm |=> $stable(comm_base))
      else $error("communication base changed without a write");

   a_comm_readback: assert property (
      RD && uhil_hit(ADDR, UHIL_OFF_COMM) |=> RDATA == $past(comm_base))
      else $error("communication base read returned a wrong value");

   a_periodic_update: assert property (
      PERIODIC_UPDATE |=> periodic_ptr == ($past(PERIODIC_ADDR) & UHIL_DESC_MASK))
      else $error("periodic pointer not updated");

   a_periodic_sw_write: assert property (
      wr_periodic && !PERIODIC_UPDATE |=> periodic_ptr == ($past(WDATA) & UHIL_DESC_MASK))
      else $error("periodic pointer did not take the write");

   a_periodic_keep: assert property (
      !PERIODIC_UPDATE && !wr_periodic |=> $stable(periodic_ptr))
      else $error("periodic pointer changed without an update");

   a_periodic_readback: assert property (
      RD && uhil_hit(ADDR, UHIL_OFF_PERIODIC) |=> RDATA == $past(periodic_ptr))
      else $error("periodic pointer read returned a wrong value");

   a_head_load: assert property (
      CONTROL_HEAD_LOAD ##1 !CONTROL_HEAD_LOAD && !wr_ctl_head
      |-> CONTROL_HEAD == ($past(CONTROL_HEAD_DATA, 1) & UHIL_DESC_MASK) ##1 $stable(CONTROL_HEAD))
      else $error("control head not loaded from shared area");

   a_head_hold: assert property (
      !CONTROL_HEAD_LOAD && !wr_ctl_head |=> $stable(CONTROL_HEAD))
      else $error("control head changed without a load or write");

   a_head_readback: assert property (
      RD && uhil_hit(ADDR, UHIL_OFF_CTL_HEAD) |=> RDATA == $past(control_head_ptr))
      else $error("control head read returned a wrong value");

   a_head_reserved: assert property (
      RD && uhil_hit(ADDR, UHIL_OFF_CTL_HEAD) |=> RDATA[3:0] == 4'h0)
      else $error("control head reserved bits not zero");

   a_current_adv: assert property (
      CONTROL_ADVANCE |=> CONTROL_CURRENT == ($past(CONTROL_NEXT) & UHIL_DESC_MASK))
      else $error("control current pointer not advanced");

   a_current_sw_write: assert property (
      wr_ctl_cur && !CONTROL_ADVANCE |=> CONTROL_CURRENT == ($past(WDATA) & UHIL_DESC_MASK))
      else $error("control current pointer did not take the write");

   a_current_keep: assert property (
      !CONTROL_ADVANCE && !wr_ctl_cur |=> $stable(CONTROL_CURRENT))
      else $error("control current pointer changed without an advance");

   a_current_readback: assert property (
      RD && uhil_hit(ADDR, UHIL_OFF_CTL_CUR) |=> RDATA == $past(control_current_ptr))
      else $error("control current read returned a wrong value");

   a_irq_gate: assert property (
      IRQ_REQ == (irq_en[UHIL_BIT_MASTER] && ((EVENT_STATUS & irq_en & UHIL_EVENT_MASK) != 32'h00000000)))
      else $error("interrupt request does not follow event, enable and master");

   a_irq_master_off: assert property (
      !irq_en[UHIL_BIT_MASTER] |-> !IRQ_REQ)
      else $error("interrupt requested with the master gate off");

   a_enable_set: assert property (
      wr_enable |=> (irq_en & $past(WDATA) & UHIL_IRQ_IMPL_MASK) == ($past(WDATA) & UHIL_IRQ_IMPL_MASK)
      && (($past(irq_en) & ~irq_en) == 32'h00000000))
      else $error("enable write did not set or cleared a bit");

   a_ptr_reserved: assert property (
      RD && (uhil_hit(ADDR, UHIL_OFF_PERIODIC) || uhil_hit(ADDR, UHIL_OFF_CTL_CUR))
      |=> RDATA[3:0] == 4'h0)
      else $error("reserved pointer bits not zero");

   c_irq_raised: cover property (wr_enable ##[1:12] IRQ_REQ);
   c_master_disabled: cover property (IRQ_REQ ##1 wr_disable && WDATA[UHIL_BIT_MASTER] ##1 !IRQ_REQ);
   c_align_probe: cover property (wr_comm && WDATA == 32'hFFFFFFFF ##[1:2] RD && uhil_hit(ADDR, UHIL_OFF_COMM));
   c_advance_read: cover property (CONTROL_ADVANCE ##[1:2] RD && uhil_hit(ADDR, UHIL_OFF_CTL_CUR));
   c_periodic_read: cover property (PERIODIC_UPDATE ##[1:2] RD && uhil_hit(ADDR, UHIL_OFF_PERIODIC));

endmodule // uhil_regs
`default_nettype wire

// >>> verif/uhil_list_model.sv
`timescale 1ns/1ns
`default_nettype none
// Stand-in for the list engine: one strobe per pointer, shared data lines
module uhil_list_model (
   input wire logic clk,
   output var logic [2:0] strobe,
   output var logic [31:0] data
);
   logic [31:0] last;

   initial begin
      strobe = 3'h0;
      data = 32'h00000000;
      last = 32'h00000000;
   end

   // Kind 0 periodic done, 1 head load at init, 2 control advance
   task automatic pulse(input int kind, input logic [31:0] d);
      @(posedge clk);
      strobe <= 3'h1 << kind;
      data <= d;
      last = d;
      @(posedge clk);
      strobe <= 3'h0;
      // Idle data lines carry garbage, never the last value
      data <= ~last;
      // Caller looks at the loaded register once it has settled
      #1;
   endtask
endmodule // uhil_list_model
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import uhil_pkg::*;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic SW_RESET = 1'b0;
   logic [7:0] ADDR = 8'h00;
   logic [31:0] WDATA = 32'h00000000;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic [31:0] EVENT_STATUS = 32'h00000000;
   logic [31:0] RDATA, IRQ_ENABLE, COMM_AREA_BASE, PERIODIC_CURRENT, CONTROL_HEAD, CONTROL_CURRENT;
   logic IRQ_REQ;
   logic [2:0] strobe;
   logic [31:0] eng_data;
   int fail_count = 0;
   int n_checks = 0;
   int bits [8] = '{31, 30, 6, 5, 3, 2, 1, 0};

   always #5 CLK = ~CLK;

   uhil_list_model eng_u (.clk(CLK), .strobe(strobe), .data(eng_data));

   uhil_regs dut_u (
      .CLK(CLK), .RST(RST), .SW_RESET(SW_RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .EVENT_STATUS(EVENT_STATUS), .IRQ_REQ(IRQ_REQ), .IRQ_ENABLE(IRQ_ENABLE),
      .PERIODIC_UPDATE(strobe[0]), .PERIODIC_ADDR(eng_data), .CONTROL_HEAD_LOAD(strobe[1]),
      .CONTROL_HEAD_DATA(eng_data), .CONTROL_ADVANCE(strobe[2]), .CONTROL_NEXT(eng_data),
      .COMM_AREA_BASE(COMM_AREA_BASE), .PERIODIC_CURRENT(PERIODIC_CURRENT),
      .CONTROL_HEAD(CONTROL_HEAD), .CONTROL_CURRENT(CONTROL_CURRENT)
   );

   task automatic test_done();
      $display("Checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CLK);
      WR <= 1'b0;
      #1;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge CLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CLK);
      RD <= 1'b0;
      #1;
      chk(RDATA, exp);
   endtask

   initial begin
      repeat (20000) @(posedge CLK);
      fail_count++;
      test_done();
   end

   initial begin
      repeat (5) @(posedge CLK);
      RST <= 1'b0;
      for (int a = 16; a <= 36; a += 4) begin
         rchk(8'(a), 32'h00000000);
      end
      chk({31'h0, IRQ_REQ}, 32'h00000000);
      wr(8'h10, 32'hFFFFFFFF);
      rchk(8'h10, 32'hC000006F);
      rchk(8'h14, 32'hC000006F);
      foreach (bits[i]) begin
         wr(8'h10, 32'hFFFFFFFF);
         wr(8'h14, 32'h00000001 << bits[i]);
         rchk(8'h14, 32'hC000006F & ~(32'h00000001 << bits[i]));
      end
      wr(8'h10, 32'hFFFFFFFF);
      wr(8'h14, 32'h00000000);
      rchk(8'h10, 32'hC000006F);
      wr(8'h14, 32'h00000010);
      rchk(8'h10, 32'hC000006F);
      // Interrupt gating: event, its enable and the master gate
      @(posedge CLK);
      EVENT_STATUS <= 32'h00000001;
      #1;
      chk({31'h0, IRQ_REQ}, 32'h00000001);
      wr(8'h14, 32'h00000001);
      chk({31'h0, IRQ_REQ}, 32'h00000000);
      @(posedge CLK);
      EVENT_STATUS <= 32'h00000004;
      #1;
      chk({31'h0, IRQ_REQ}, 32'h00000001);
      wr(8'h14, 32'h80000000);
      chk({31'h0, IRQ_REQ}, 32'h00000000);
      chk(IRQ_ENABLE, 32'h4000006E);
      wr(8'h18, 32'hFFFFFFFF);
      rchk(8'h18, 32'hFFFFFF00);
      wr(8'h18, 32'h12345678);
      rchk(8'h18, 32'h12345600);
      chk(COMM_AREA_BASE, 32'h12345600);
      eng_u.pulse(0, 32'hABCDEF1F);
      chk(PERIODIC_CURRENT, 32'hABCDEF10);
      rchk(8'h1C, 32'hABCDEF10);
      wr(8'h1C, 32'hFFFFFFFF);
      rchk(8'h1C, 32'hFFFFFFF0);
      eng_u.pulse(1, 32'h0000A5AF);
      chk(CONTROL_HEAD, 32'h0000A5A0);
      wr(8'h20, 32'h5555555F);
      rchk(8'h20, 32'h55555550);
      wr(8'h24, 32'hFFFFFFFF);
      rchk(8'h24, 32'hFFFFFFF0);
      eng_u.pulse(2, 32'h1234567F);
      rchk(8'h24, 32'h12345670);
      chk(CONTROL_CURRENT, 32'h12345670);
      wr(8'h28, 32'hFFFFFFFF);
      rchk(8'h28, 32'h00000000);
      rchk(8'h18, 32'h12345600);
      // Software reset clears the whole bank
      @(posedge CLK);
      SW_RESET <= 1'b1;
      @(posedge CLK);
      SW_RESET <= 1'b0;
      #1;
      chk(IRQ_ENABLE | COMM_AREA_BASE | PERIODIC_CURRENT, 32'h00000000);
      chk(CONTROL_HEAD | CONTROL_CURRENT, 32'h00000000);
      rchk(8'h14, 32'h00000000);
      test_done();
   end
endmodule // tb_top
`default_nettype wire
